// [core/pmcap_reg.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: aux current zero when data register present
// R2: aux current zero without cold wake
// R3: aux code encodes maximum auxiliary draw
// R4: bit 5 flags device specific init
// R5: bit 3 flags bus clock wake dependence
// R6: no wake anywhere forces bit 3 zero
// R7: version field reads 010b
// R8: strap high sets cold wake bit
// R9: strap low or open clears bit
// R10: bits 15..11 wake support per state
// R11: strap defaults differ full/high-speed function
// R12: word read-only, writes ignored, bit 4 zero
module pmcap_reg #(
  parameter bit HIGH_SPEED_FN = 1'b1,          // high-speed host function
  parameter bit HAS_DATA_REG = 1'b0,           // power data register present
  parameter logic [2:0] AUX_CODE = pmcap_pkg::AUX_DEFAULT,
  parameter bit NEEDS_DEV_INIT = 1'b0,
  parameter bit WAKE_NEEDS_CLK = 1'b0,
  parameter bit D1_SUPPORT = 1'b1,
  parameter bit D2_SUPPORT = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic cold_wake_strap_pin,        // asynchronous strap
  input wire logic cfg_rd,                     // config read strobe
  input wire logic cfg_wr,                     // config write strobe
  input wire logic [7:0] cfg_addr,             // config byte address
  input wire logic [15:0] cfg_wdata,           // ignored, word is read-only
  output logic [15:0] cfg_rdata,               // read data
  output logic cfg_ack,                        // one cycle completion
  output logic [15:0] power_capabilities,      // live word
  output logic strap_valid                     // strap has been latched
);
  import pmcap_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // strap capture
  logic strap_sync; // synchronised strap level
  logic [3:0] settle_q; // count after reset release
  logic cold_wake_support_bit_q; // latched strap

  pmcap_sync u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(cold_wake_strap_pin),
    .sync_out(strap_sync)
  );

  // latch strap once after release; reset only takes constants
  always_ff @(posedge clk) begin
    if (reset) begin
      settle_q <= 4'h0;
      strap_valid <= 1'b0;
      cold_wake_support_bit_q <= 1'b0;
    end else if (!strap_valid) begin
      if (settle_q == STRAP_SETTLE) begin
        strap_valid <= 1'b1;
        cold_wake_support_bit_q <= strap_sync; // see R8 see R9
      end else begin
        settle_q <= settle_q + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // word composition
  logic [4:0] wake_state_support; // per state wake flags
  logic any_wake; // wake possible somewhere
  logic [2:0] aux_field; // auxiliary current code
  logic [15:0] word_d; // assembled word

  // strap dependent bits follow function kind, cold bit follows strap
  always_comb begin
    wake_state_support[4] = cold_wake_support_bit_q; // see R10
    // d2 and d0 wake are the kind dependent defaults, d3hot and d1 always set
    wake_state_support[3:0] = HIGH_SPEED_FN ? 4'hf : WAKE_LOW_DEFAULT; // see R11
    any_wake = |wake_state_support;
    // data register or no cold wake wins over code
    if (HAS_DATA_REG) begin
      aux_field = AUX_NONE; // see R1
    end else if (!cold_wake_support_bit_q) begin
      aux_field = AUX_NONE; // see R2
    end else begin
      aux_field = AUX_CODE; // see R3
    end
    word_d = 16'h0000; // reserved bit 4 stays zero, see R12
    word_d[WAKE_HI:WAKE_LO] = wake_state_support;
    word_d[D2_BIT] = D2_SUPPORT & HIGH_SPEED_FN; // see R11
    word_d[D1_BIT] = D1_SUPPORT;
    word_d[AUX_HI:AUX_LO] = aux_field;
    word_d[DSI_BIT] = NEEDS_DEV_INIT; // see R4
    // clock dependence only meaningful when wake exists
    word_d[CLKDEP_BIT] = WAKE_NEEDS_CLK & any_wake; // see R5 see R6
    word_d[VER_HI:VER_LO] = PM_SPEC_VERSION; // see R7
  end

  ////////////////////////////////////////////////////////////////////////
  // config access
  // registered outputs; writes acked and discarded
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_rdata <= 16'h0000;
      cfg_ack <= 1'b0;
      power_capabilities <= 16'h0000;
    end else begin
      power_capabilities <= word_d;
      cfg_ack <= cfg_rd | cfg_wr; // see R12
      if (cfg_rd && cfg_addr == PM_CAP_OFFSET) begin
        cfg_rdata <= word_d;
      end else if (cfg_rd) begin
        cfg_rdata <= 16'h0000; // unmapped reads zero
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_aux_zero;
    @(posedge clk) disable iff (reset)
      !power_capabilities[WAKE_HI] |-> power_capabilities[AUX_HI:AUX_LO] == 3'h0;
  endproperty
  a_aux_zero: assert property (p_aux_zero) else $error("aux current nonzero without cold wake"); // see R2

  property p_version;
    @(posedge clk) disable iff (reset)
      $past(!reset) |-> power_capabilities[2:0] == 3'h2;
  endproperty
  a_version: assert property (p_version) else $error("version field wrong"); // see R7

  property p_rsvd;
    @(posedge clk) disable iff (reset) power_capabilities[4] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // see R12

  property p_wr_ignored;
    @(posedge clk) disable iff (reset)
      strap_valid && cfg_wr |=> ##1 $stable(power_capabilities);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write changed word"); // see R12

  property p_ack;
    @(posedge clk) disable iff (reset) (cfg_rd || cfg_wr) |=> cfg_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged"); // see R12

  property p_strap;
    @(posedge clk) disable iff (reset)
      $rose(strap_valid) |=> power_capabilities[15] == cold_wake_support_bit_q;
  endproperty
  a_strap: assert property (p_strap) else $error("cold wake bit not from strap"); // see R8

  property p_strap_low;
    @(posedge clk) disable iff (reset)
      !strap_valid |=> power_capabilities[15] == 1'b0;
  endproperty
  a_strap_low: assert property (p_strap_low) else $error("cold wake bit set before strap"); // see R9

  property p_clkdep;
    @(posedge clk) disable iff (reset)
      power_capabilities[15:11] == 5'h00 |-> !power_capabilities[3];
  endproperty
  a_clkdep: assert property (p_clkdep) else $error("clock bit set with no wake"); // see R6

  property p_data_reg;
    @(posedge clk) disable iff (reset)
      HAS_DATA_REG |-> power_capabilities[8:6] == 3'h0;
  endproperty
  a_data_reg: assert property (p_data_reg) else $error("aux nonzero with data register"); // see R1

  property p_rdata;
    @(posedge clk) disable iff (reset)
      cfg_rd && cfg_addr == 8'h36 |=> cfg_rdata == $past(word_d);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data mismatch"); // see R10

  // ack is a single pulse, it drops when no strobe came
  property p_ack_pulse;
    @(posedge clk) disable iff (reset) !(cfg_rd || cfg_wr) |=> !cfg_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack without access"); // see R12

  // other addresses answer zero
  property p_unmapped;
    @(posedge clk) disable iff (reset)
      cfg_rd && cfg_addr != PM_CAP_OFFSET |=> cfg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero"); // see R12

  // read data stands until the next read, writes leave it alone
  property p_rdata_hold;
    @(posedge clk) disable iff (reset) !cfg_rd |=> $stable(cfg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // see R12

  // with cold wake and no data register the configured code shows
  property p_aux_code;
    @(posedge clk) disable iff (reset)
      !HAS_DATA_REG && power_capabilities[WAKE_HI] |-> power_capabilities[AUX_HI:AUX_LO] == AUX_CODE;
  endproperty
  a_aux_code: assert property (p_aux_code) else $error("aux code not the configured draw"); // see R3

  // init flag follows the build choice once the word is loaded
  property p_dsi;
    @(posedge clk) disable iff (reset)
      $past(!reset) |-> power_capabilities[DSI_BIT] == NEEDS_DEV_INIT;
  endproperty
  a_dsi: assert property (p_dsi) else $error("init flag wrong"); // see R4

  // clock dependence bit follows WAKE_NEEDS_CLK whenever some wake exists
  property p_clk_need;
    @(posedge clk) disable iff (reset)
      power_capabilities[WAKE_HI:WAKE_LO] != 5'h00 |-> power_capabilities[CLKDEP_BIT] == WAKE_NEEDS_CLK;
  endproperty
  a_clk_need: assert property (p_clk_need) else $error("clock dependence bit wrong"); // see R5

  // strap is latched once; only a reset may sample it again
  property p_valid_hold;
    @(posedge clk) disable iff (reset) strap_valid |=> strap_valid;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("strap latch dropped"); // see R8

  // d2 and d0 wake bits follow the function kind
  property p_wake_kind;
    @(posedge clk) disable iff (reset)
      $past(!reset) |-> power_capabilities[WAKE_LO + 2] == HIGH_SPEED_FN
        && power_capabilities[WAKE_LO] == HIGH_SPEED_FN;
  endproperty
  a_wake_kind: assert property (p_wake_kind) else $error("kind dependent wake bits wrong"); // see R11
endmodule // pmcap_reg
`default_nettype wire

// [core/pmcap_pkg.sv]
package pmcap_pkg;
  // field positions of the capabilities word
  localparam int unsigned WAKE_HI = 15;
  localparam int unsigned WAKE_LO = 11;
  localparam int unsigned D2_BIT = 10;
  localparam int unsigned D1_BIT = 9;
  localparam int unsigned AUX_HI = 8;
  localparam int unsigned AUX_LO = 6;
  localparam int unsigned DSI_BIT = 5;
  localparam int unsigned RSVD_BIT = 4;
  localparam int unsigned CLKDEP_BIT = 3;
  localparam int unsigned VER_HI = 2;
  localparam int unsigned VER_LO = 0;
  // reset and fixed values
  localparam logic [2:0] PM_SPEC_VERSION = 3'h2;    // revision 1.1
  localparam logic [2:0] AUX_NONE = 3'h0;           // self powered
  localparam logic [2:0] AUX_DEFAULT = 3'h2;        // 100 mA draw
  localparam logic [3:0] WAKE_LOW_DEFAULT = 4'ha;   // full-speed function: d3hot and d1 wake only
  localparam logic [7:0] PM_CAP_OFFSET = 8'h36;     // capability base 34h plus 2
  // strap sampling: cycles after reset release before strap is latched
  localparam logic [3:0] STRAP_SETTLE = 4'h4;
endpackage : pmcap_pkg

// [core/pmcap_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// two flop level synchroniser for an asynchronous pin
module pmcap_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q; // first stage, read only by second stage
  // two stage chain
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pmcap_sync
`default_nettype wire

// [sim/pmcap_host.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// config host: one strobe pulse per access, answer taken on the ack edge
module pmcap_host (
  input wire logic clk,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_ack,
  output logic cfg_rd = 1'b0,
  output logic cfg_wr = 1'b0,
  output logic [7:0] cfg_addr = 8'h00,
  output logic [15:0] cfg_wdata = 16'h0000
);
  // issue, drop strobe after the taking edge, sample ack one edge later
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                        output logic [15:0] rd, output logic ack);
    @(posedge clk);
    cfg_rd <= ~wr;
    cfg_wr <= wr;
    cfg_addr <= a;
    cfg_wdata <= wd;
    @(posedge clk);
    cfg_rd <= 1'b0;
    cfg_wr <= 1'b0;
    @(posedge clk);
    rd = cfg_rdata;
    ack = cfg_ack;
    // data lines no longer meaningful, so show a changed pattern
    cfg_wdata <= ~wd;
  endtask
endmodule // pmcap_host
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  import pmcap_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b1; // strap level seen at power-on
  logic rd, wr, ack, ack2, valid, valid2, ack_got;
  logic [7:0] addr;
  logic [15:0] wd, rdata, rdata2, word, word2, word3, got;
  int n_mismatch = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  // default build plus a copy with the data register present
  pmcap_reg dut (.clk(clk), .reset(reset), .cold_wake_strap_pin(strap), .cfg_rd(rd), .cfg_wr(wr),
    .cfg_addr(addr), .cfg_wdata(wd), .cfg_rdata(rdata), .cfg_ack(ack), .power_capabilities(word),
    .strap_valid(valid));
  pmcap_reg #(.HAS_DATA_REG(1'b1)) dut2 (.clk(clk), .reset(reset), .cold_wake_strap_pin(strap),
    .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(addr), .cfg_wdata(wd), .cfg_rdata(rdata2), .cfg_ack(ack2),
    .power_capabilities(word2), .strap_valid(valid2));
  // full-speed build with init flag, clock dependence and top aux code
  pmcap_reg #(.HIGH_SPEED_FN(1'b0), .AUX_CODE(3'h7), .NEEDS_DEV_INIT(1'b1), .WAKE_NEEDS_CLK(1'b1)) dut3 (
    .clk(clk), .reset(reset), .cold_wake_strap_pin(strap), .cfg_rd(rd), .cfg_wr(wr), .cfg_addr(addr),
    .cfg_wdata(wd), .cfg_rdata(), .cfg_ack(), .power_capabilities(word3), .strap_valid());
  pmcap_host host (.clk(clk), .cfg_rdata(rdata), .cfg_ack(ack), .cfg_rd(rd), .cfg_wr(wr),
    .cfg_addr(addr), .cfg_wdata(wd));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // power-on: strap is only sampled after a fresh reset
  task automatic por(input logic s);
    int n;
    strap <= s;
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    for (n = 0; n < 40 && valid !== 1'b1; n++) @(posedge clk);
    chk({15'h0, valid}, 16'h1);
    chk({15'h0, valid2}, 16'h1);
    repeat (2) @(posedge clk);
  endtask
  // read both copies, expect ack on the answer edge
  task automatic rd_word(input logic [7:0] a, input logic [15:0] e, input logic [15:0] e2);
    host.access(1'b0, a, 16'h0000, got, ack_got);
    chk({15'h0, ack_got}, 16'h1);
    chk({15'h0, ack2}, 16'h1);
    chk(got, e);
    chk(rdata2, e2);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // watchdog: whole run is about 50 cycles, limit is 3000 cycles
  initial begin
    #(4 * 3000);
    n_mismatch++;
    results();
  end
  initial begin
    por(1'b1);
    rd_word(PM_CAP_OFFSET, 16'hfe82, 16'hfe02);
    chk(word3, 16'hd3ea);
    host.access(1'b1, PM_CAP_OFFSET, 16'h0000, got, ack_got);
    chk({15'h0, ack_got}, 16'h1);
    rd_word(PM_CAP_OFFSET, 16'hfe82, 16'hfe02);
    chk(word, 16'hfe82);
    rd_word(8'h34, 16'h0000, 16'h0000);
    $display("test strap_high done");
    por(1'b0);
    rd_word(PM_CAP_OFFSET, 16'h7e02, 16'h7e02);
    chk(word2, 16'h7e02);
    chk(word3, 16'h522a);
    $display("test strap_low done");
    results();
  end
endmodule // tb_top
`default_nettype wire
